// ==== common/lq_cfg.svh ====
// Register map, field positions, reset values and timing counts of the low-power state control
`ifndef LQ_CFG_SVH
`define LQ_CFG_SVH
`define ADDR_LOWPWR   7'h01
`define ADDR_SWITCH   7'h02
`define ADDR_DEVSTAT  7'h03
`define ADDR_FAULTSUM 7'h04
`define ADDR_WDOG     7'h05
`define LP_BIT        0
`define WAKE_SEL_LSB  1
`define WDOG_EN_BIT   0
`define FS_FALLBACK   0
`define FS_LQWAKE     1
`define FS_OC_LSB     2
`define FS_VBBUV      4
`define LOWPWR_RST    16'h0000
`define SWITCH_RST    16'h0000
`define DEVSTAT_RST   16'h0000
`define WDOG_RST      16'h0000
`define WAKE_MA_00    10'd600
`define WAKE_MA_01    10'd800
`define WAKE_MA_10    10'd200
`define WAKE_MA_11    10'd400
`define FRAME_BITS    24
`define CLK_NS        25
`define WD_TIME_US    1000
`define HOST_GAP      5'd16
`endif

// ==== common/lq_pkg.sv ====
// Types shared by both ends of the low-power state control link
package lq_pkg;
   typedef enum logic [3:0] {
      ST_ACTIVE   = 4'b0001,
      ST_ENTRY    = 4'b0010,
      ST_LOWQ     = 4'b0100,
      ST_FALLBACK = 4'b1000
   } mode_t;
   typedef enum logic [2:0] {
      H_IDLE  = 3'b001,
      H_SHIFT = 3'b010,
      H_GAP   = 3'b100
   } host_st_t;
endpackage

// ==== common/lq_link_if.sv ====
// Serial link between the host controller and the switch device
`timescale 1ns/1ps
interface lq_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo_out;
   logic sdo_oe;
   wire  sdo;
   // Pull-up on the serial output while the device does not drive it
   assign sdo = sdo_oe ? sdo_out : 1'b1;
   modport dev  (input sclk, input cs_n, input sdi, output sdo_out, output sdo_oe);
   modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface

// ==== rtl/lq_device.sv ====
// Device end: serial register port, low-quiescent and fallback state control
// Functional notes
// - Low-power bit write enters low-quiescent state
// - Host sets switch states before entry
// - Output changes ignored while low-quiescent
// - Entry waits for inrush of enabled channels
// - Configuration retained in low-quiescent state
// - No channel switches during entry transition
// - Off channel turns on only after exit
// - Logic supply loss resets all configuration
// - Of host writes, only one clearing low-power bit exits
// - Status read clears flag, releases alert line
// - Wake select 00/01/10/11 = 600/800/200/400mA
// - Load above threshold wakes, alert falls
// - Overcurrent fault recorded only when active
// - After auto wake bit stays set
// - Fast second trip restarts channel when active
// - Channel off at entry stays off
// - Host clears faults before entry
// - No thermal watch while low-quiescent; undervoltage turns outputs off only there
// - Request pin or watchdog enters fallback
// - Fallback outputs follow fallback state bits
// - Fallback entry sets summary flag
// - Register writes rejected during fallback
// - Exit fallback: pin low, write one
// - Fallback bits 00 follow drive input pin
`timescale 1ns/1ps
`include "lq_cfg.svh"
module lq_device
   import lq_pkg::*;
#(
   parameter logic [16:0] WD_CYCLES = 17'(`WD_TIME_US * 1000 / `CLK_NS)
)(
   input  wire logic             clock,
   input  wire logic             sys_rst,
   lq_link_if.dev                link,
   input  wire logic             fallback_request_in,
   input  wire logic             fallback_drive_in,
   input  wire logic [1:0]       inrush_done,
   input  wire logic [1:0][9:0]  load_ma,
   input  wire logic [1:0]       fast_trip,
   input  wire logic [1:0]       oc_confirm,
   input  wire logic [1:0]       thermal_off,
   input  wire logic             vbb_uv,
   output logic      [1:0]       ch_on,
   output logic                  fault_alert_out_n,
   output mode_t                 mode
);
   ////////////////////////////////////////////////////////////////////////////////
   // Link clock domain: frame capture and response shift-out
   logic        frame_rst;
   logic [4:0]  bit_cnt_r;
   logic [22:0] shift_r;
   logic [23:0] frame_r;
   logic        frame_tgl_r;
   logic        loaded_r;
   logic [23:0] out_sh_r;
   logic [23:0] resp_r;

   assign frame_rst = sys_rst | link.cs_n;

   always_ff @(negedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= 5'd0;
         shift_r   <= 23'h000000;
      end else begin
         shift_r <= {shift_r[21:0], link.sdi};
         if (bit_cnt_r != 5'(`FRAME_BITS))
            bit_cnt_r <= bit_cnt_r + 5'd1;
      end
   end

   // Only the exact last bit of a frame publishes it; extra bits are dropped
   always_ff @(negedge link.sclk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_r     <= 24'h000000;
         frame_tgl_r <= 1'b0;
      end else if (!link.cs_n && bit_cnt_r == 5'(`FRAME_BITS - 1)) begin
         frame_r     <= {shift_r, link.sdi};
         frame_tgl_r <= ~frame_tgl_r;
      end
   end

   // Response is quasi-static: it only changes after a frame has ended
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         loaded_r <= 1'b0;
         out_sh_r <= 24'h000000;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         out_sh_r <= resp_r;
      end else begin
         out_sh_r <= {out_sh_r[22:0], 1'b0};
      end
   end

   assign link.sdo_out = out_sh_r[23];
   assign link.sdo_oe  = ~link.cs_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Crossings into the core clock
   logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
   logic req_s1_r, req_s2_r, drv_s1_r, drv_s2_r;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         {tgl_s1_r, tgl_s2_r, tgl_s3_r} <= 3'b000;
         {req_s1_r, req_s2_r, drv_s1_r, drv_s2_r} <= 4'b0000;
      end else begin
         tgl_s1_r <= frame_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         req_s1_r <= fallback_request_in;
         req_s2_r <= req_s1_r;
         drv_s1_r <= fallback_drive_in;
         drv_s2_r <= drv_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode
   mode_t       mode_r;
   logic [15:0] lp_r, sw_r, stat_r, wdog_r;
   logic [1:0]  oc_r, lq_out_r, restart_r, ch_on_r, wake, fb_out;
   logic        lqflag_r, fb_flag_r, alert_n_r;
   logic [16:0] wd_cnt_r;
   logic        f_valid, f_wr, wr_ok, lp_enter, exit_cmd, fs_rd, fb_go, fb_clr, wd_expire;
   logic [6:0]  f_addr;
   logic [15:0] f_data, fsum, rdata;

   assign f_valid  = tgl_s2_r ^ tgl_s3_r;
   assign f_wr     = frame_r[23];
   assign f_addr   = frame_r[22:16];
   assign f_data   = frame_r[15:0];
   assign wr_ok    = f_valid & f_wr & (mode_r == ST_ACTIVE);
   assign lp_enter = wr_ok & (f_addr == `ADDR_LOWPWR) & f_data[`LP_BIT]
                     & ~lp_r[`LP_BIT];
   assign exit_cmd = f_valid & f_wr & (mode_r == ST_LOWQ) & (f_addr == `ADDR_LOWPWR)
                     & ~f_data[`LP_BIT];
   assign fs_rd    = f_valid & ~f_wr & (f_addr == `ADDR_FAULTSUM) & (mode_r != ST_LOWQ);
   assign wd_expire = wdog_r[`WDOG_EN_BIT] & (wd_cnt_r == WD_CYCLES);
   assign fb_go    = req_s2_r | wd_expire;
   assign fb_clr   = f_valid & f_wr & (mode_r == ST_FALLBACK) & ~req_s2_r
                     & (f_addr == `ADDR_FAULTSUM) & f_data[`FS_FALLBACK];

   always_comb begin
      fsum = 16'h0000;
      fsum[`FS_FALLBACK] = fb_flag_r;
      fsum[`FS_LQWAKE] = lqflag_r;
      fsum[`FS_OC_LSB +: 2] = oc_r;
      fsum[`FS_VBBUV] = vbb_uv;
   end

   always_comb begin
      if (f_addr == `ADDR_LOWPWR)
         rdata = lp_r;
      else if (f_addr == `ADDR_SWITCH)
         rdata = sw_r;
      else if (f_addr == `ADDR_DEVSTAT)
         rdata = stat_r;
      else if (f_addr == `ADDR_FAULTSUM)
         rdata = fsum;
      else if (f_addr == `ADDR_WDOG)
         rdata = wdog_r;
      else
         rdata = 16'h0000;
   end

   // Reads return the addressed register, writes return the fault summary
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         resp_r <= 24'h000000;
      else if (f_valid)
         resp_r <= {8'h00, f_wr ? fsum : rdata};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers, cleared only by power-on reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lp_r   <= `LOWPWR_RST;
         sw_r   <= `SWITCH_RST;
         stat_r <= `DEVSTAT_RST;
         wdog_r <= `WDOG_RST;
      end else if (wr_ok) begin
         if (f_addr == `ADDR_LOWPWR)
            lp_r <= f_data;
         else if (f_addr == `ADDR_SWITCH)
            sw_r <= f_data;
         else if (f_addr == `ADDR_DEVSTAT)
            stat_r <= f_data;
         else if (f_addr == `ADDR_WDOG)
            wdog_r <= f_data;
      end else if (exit_cmd) begin
         lp_r[`LP_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         wd_cnt_r <= 17'd0;
      else if (!wdog_r[`WDOG_EN_BIT] || mode_r != ST_ACTIVE || f_valid)
         wd_cnt_r <= 17'd0;
      else if (wd_cnt_r != WD_CYCLES)
         wd_cnt_r <= wd_cnt_r + 17'd1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel wake threshold, fallback drive and overcurrent record
   for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      logic [1:0] sel;
      logic [1:0] fbs;
      logic [9:0] thr;
      assign sel = lp_r[`WAKE_SEL_LSB + 2 * gi +: 2];
      assign fbs = stat_r[2 * gi +: 2];
      always_comb begin
         case (sel)
            2'b00:   thr = `WAKE_MA_00;
            2'b01:   thr = `WAKE_MA_01;
            2'b10:   thr = `WAKE_MA_10;
            default: thr = `WAKE_MA_11;
         endcase
      end
      assign wake[gi] = lq_out_r[gi] & ((load_ma[gi] > thr) | fast_trip[gi]);
      // 00 follows the drive pin, 01 off, 1x on
      assign fb_out[gi] = (fbs == 2'b00) ? drv_s2_r : fbs[1];
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst)
            oc_r[gi] <= 1'b0;
         else if (mode_r == ST_ACTIVE && oc_confirm[gi])
            oc_r[gi] <= 1'b1;
         else if (fs_rd)
            oc_r[gi] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode sequencer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= ST_ACTIVE;
      end else begin
         case (mode_r)
            ST_ACTIVE: begin
               if (fb_go)
                  mode_r <= ST_FALLBACK;
               else if (lp_enter)
                  mode_r <= ST_ENTRY;
            end
            ST_ENTRY: begin
               if (fb_go)
                  mode_r <= ST_FALLBACK;
               else if (&(inrush_done | ~ch_on_r))
                  mode_r <= ST_LOWQ;
            end
            ST_LOWQ: begin
               if (req_s2_r)
                  mode_r <= ST_FALLBACK;
               else if (exit_cmd || |wake)
                  mode_r <= ST_ACTIVE;
            end
            ST_FALLBACK: begin
               if (fb_clr)
                  mode_r <= ST_ACTIVE;
            end
            default: mode_r <= ST_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lq_out_r  <= 2'b00;
         restart_r <= 2'b00;
      end else begin
         if (mode_r == ST_ENTRY)
            lq_out_r <= ch_on_r & ~thermal_off;
         if (mode_r == ST_LOWQ && exit_cmd)
            restart_r <= sw_r[1:0] & ~lq_out_r;
         else if (mode_r == ST_LOWQ && |wake)
            restart_r <= lq_out_r & fast_trip;
         else
            restart_r <= 2'b00;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ch_on_r <= 2'b00;
      end else begin
         case (mode_r)
            ST_ACTIVE:   ch_on_r <= sw_r[1:0] & ~thermal_off & ~restart_r;
            ST_ENTRY:    ch_on_r <= ch_on_r;
            ST_LOWQ:     ch_on_r <= lq_out_r & ~fast_trip & {2{~vbb_uv}};
            ST_FALLBACK: ch_on_r <= fb_out;
            default:     ch_on_r <= 2'b00;
         endcase
      end
   end

   // Flags: a set in the same cycle as a clear wins
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lqflag_r  <= 1'b0;
         fb_flag_r <= 1'b0;
         alert_n_r <= 1'b1;
      end else begin
         if (mode_r == ST_LOWQ && (exit_cmd || |wake))
            lqflag_r <= 1'b1;
         else if (fs_rd)
            lqflag_r <= 1'b0;
         if (fb_go && mode_r != ST_FALLBACK)
            fb_flag_r <= 1'b1;
         else if (fb_clr)
            fb_flag_r <= 1'b0;
         alert_n_r <= ~(lqflag_r | fb_flag_r | |oc_r);
      end
   end

   assign ch_on             = ch_on_r;
   assign fault_alert_out_n = alert_n_r;
   assign mode              = mode_r;
endmodule

// ==== rtl/lq_host.sv ====
// Host end: serial master with a single-command port and a low-power entry sequence
`timescale 1ns/1ps
`include "lq_cfg.svh"
module lq_host
   import lq_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         sys_rst,
   lq_link_if.host           link,
   input  wire logic         cmd_valid,
   input  wire logic         cmd_write,
   input  wire logic [6:0]   cmd_addr,
   input  wire logic [15:0]  cmd_wdata,
   output logic              cmd_ready,
   input  wire logic         lq_enter_valid,
   input  wire logic [1:0]   lq_sw_set,
   input  wire logic [15:0]  lq_wake_cfg,
   output logic              rsp_valid,
   output logic [15:0]       rsp_data
);
   host_st_t    st_r;
   logic [1:0]  ph_r, step_r, sw_hold_r, samp_d_r, last_d_r;
   logic [4:0]  bit_r, gap_r;
   logic [23:0] tx_r, rx_r;
   logic [15:0] cfg_hold_r;
   logic        seq_r, cs_n_r, sdo_s1_r, sdo_s2_r, rsp_valid_r;

   // Steps: clear faults, set switches, low-power bit to 0, then to 1
   function automatic logic [23:0] enter_frame(input logic [1:0]  step,
                                               input logic [1:0]  sw,
                                               input logic [15:0] cfg);
      logic [15:0] lo;
      lo = cfg;
      lo[`LP_BIT] = 1'b0;
      case (step)
         2'd0:    enter_frame = {1'b0, `ADDR_FAULTSUM, 16'h0000};
         2'd1:    enter_frame = {1'b1, `ADDR_SWITCH, 14'h0000, sw};
         2'd2:    enter_frame = {1'b1, `ADDR_LOWPWR, lo};
         default: enter_frame = {1'b1, `ADDR_LOWPWR, lo | 16'h0001};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Frame sequencer; caller may start entry while a channel inrush is still running
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r       <= H_IDLE;
         ph_r       <= 2'd0;
         bit_r      <= 5'd0;
         gap_r      <= 5'd0;
         tx_r       <= 24'h000000;
         cs_n_r     <= 1'b1;
         seq_r      <= 1'b0;
         step_r     <= 2'd0;
         sw_hold_r  <= 2'b00;
         cfg_hold_r <= 16'h0000;
      end else begin
         case (st_r)
            H_IDLE: begin
               ph_r  <= 2'd0;
               bit_r <= 5'd0;
               if (lq_enter_valid) begin
                  seq_r      <= 1'b1;
                  step_r     <= 2'd0;
                  sw_hold_r  <= lq_sw_set;
                  cfg_hold_r <= lq_wake_cfg;
                  tx_r       <= enter_frame(2'd0, lq_sw_set, lq_wake_cfg);
                  cs_n_r     <= 1'b0;
                  st_r       <= H_SHIFT;
               end else if (cmd_valid) begin
                  tx_r   <= {cmd_write, cmd_addr, cmd_wdata};
                  cs_n_r <= 1'b0;
                  st_r   <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               ph_r <= ph_r + 2'd1;
               if (ph_r == 2'd1 && bit_r != 5'd0)
                  tx_r <= {tx_r[22:0], 1'b0};
               if (ph_r == 2'd3) begin
                  if (bit_r == 5'(`FRAME_BITS - 1)) begin
                     gap_r  <= 5'd0;
                     st_r   <= H_GAP;
                  end else begin
                     bit_r <= bit_r + 5'd1;
                  end
               end
            end
            H_GAP: begin
               gap_r <= gap_r + 5'd1;
               // Select rises a clock after the last link clock fall
               if (gap_r == 5'd0)
                  cs_n_r <= 1'b1;
               if (gap_r == `HOST_GAP) begin
                  ph_r  <= 2'd0;
                  bit_r <= 5'd0;
                  if (seq_r && step_r != 2'd3) begin
                     step_r <= step_r + 2'd1;
                     tx_r   <= enter_frame(step_r + 2'd1, sw_hold_r, cfg_hold_r);
                     cs_n_r <= 1'b0;
                     st_r   <= H_SHIFT;
                  end else begin
                     seq_r <= 1'b0;
                     st_r  <= H_IDLE;
                  end
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response capture two clocks after each sample point
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         {sdo_s1_r, sdo_s2_r} <= 2'b11;
         samp_d_r    <= 2'b00;
         last_d_r    <= 2'b00;
         rx_r        <= 24'h000000;
         rsp_valid_r <= 1'b0;
      end else begin
         sdo_s1_r    <= link.sdo;
         sdo_s2_r    <= sdo_s1_r;
         samp_d_r    <= {samp_d_r[0], st_r == H_SHIFT && ph_r == 2'd3};
         last_d_r    <= {last_d_r[0], st_r == H_SHIFT && ph_r == 2'd3
                         && bit_r == 5'(`FRAME_BITS - 1)};
         if (samp_d_r[1])
            rx_r <= {rx_r[22:0], sdo_s2_r};
         rsp_valid_r <= last_d_r[1];
      end
   end

   assign link.sclk = (st_r == H_SHIFT) & ph_r[1];
   assign link.cs_n = cs_n_r;
   assign link.sdi  = tx_r[23];
   assign cmd_ready = (st_r == H_IDLE);
   assign rsp_valid = rsp_valid_r;
   assign rsp_data  = rx_r[15:0];
endmodule

// ==== test/lq_link_monitor.sv ====
// Checker for the serial link and the device mode outputs
`timescale 1ns/1ps
module lq_link_monitor
   import lq_pkg::*;
(
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       sclk,
   input wire logic       cs_n,
   input wire logic       sdo_oe,
   input wire mode_t      mode,
   input wire logic [1:0] ch_on,
   input wire logic       fault_alert_out_n,
   input wire logic [1:0] inrush_done,
   input wire logic [1:0] fast_trip,
   input wire logic       vbb_uv,
   input wire logic       fallback_request_in,
   input wire logic       fallback_drive_in
);
   logic       sclk_d_r;
   logic [5:0] bits_r;
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // Counts link clock rising edges within one frame
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk;
      end
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bits_r <= 6'h00;
      end else if (cs_n) begin
         bits_r <= 6'h00;
      end else if (sclk && !sclk_d_r) begin
         bits_r <= bits_r + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   chk_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("link clock not low outside frame");
   chk_sdo_drive: assert property (sdo_oe == !cs_n)
      else $error("sdo enable not tied to frame select");
   chk_frame_bits: assert property ($rose(cs_n) |-> bits_r == 6'h18)
      else $error("frame did not carry 24 clocks");
   chk_reset_state: assert property (
      $fell(sys_rst) |-> mode == ST_ACTIVE && ch_on == 2'h0 && fault_alert_out_n)
      else $error("wrong state after reset");
   chk_entry_frozen: assert property (mode == ST_ENTRY |-> $stable(ch_on))
      else $error("output changed during entry");
   chk_entry_inrush: assert property (
      $past(mode) == ST_ENTRY && mode == ST_LOWQ |-> ($past(ch_on) & ~$past(inrush_done)) == 2'h0)
      else $error("entry completed during inrush");
   chk_lowq_no_on: assert property (
      $past(mode) == ST_LOWQ && mode == ST_LOWQ
      && !$past(vbb_uv, 2) && $past(fast_trip, 2) == 2'h0
      |-> (ch_on & ~$past(ch_on)) == 2'h0)
      else $error("channel turned on in low-quiescent state");
   chk_fallback_entry: assert property (
      mode == ST_ACTIVE && fallback_request_in |-> ##[1:4] mode == ST_FALLBACK)
      else $error("fallback request not taken");
   chk_fallback_hold: assert property (
      mode == ST_FALLBACK && fallback_request_in |=> mode == ST_FALLBACK)
      else $error("fallback left while requested");
   chk_fallback_alert: assert property (
      $past(mode) == ST_FALLBACK && mode == ST_FALLBACK |=> !fault_alert_out_n)
      else $error("fallback not flagged on alert line");
   chk_fallback_drive: assert property (
      (mode == ST_FALLBACK && fallback_drive_in) [*4] |-> ch_on == 2'h3)
      else $error("fallback outputs ignore drive input");
endmodule

// ==== test/low_power_and_fallback_state_ctrl_bench.sv ====
// Bench joining host and device ends across the serial link
`timescale 1ns/1ps
module low_power_and_fallback_state_ctrl_bench
   import lq_pkg::*;
();
   logic            clock, sys_rst, cmd_valid, cmd_write, cmd_ready, lq_enter_valid, rsp_valid;
   logic            fallback_request_in, fallback_drive_in, vbb_uv, fault_alert_out_n;
   logic [1:0]      lq_sw_set, inrush_done, fast_trip, oc_confirm, thermal_off, ch_on;
   logic [6:0]      cmd_addr;
   logic [15:0]     cmd_wdata, lq_wake_cfg, rsp_data, r;
   logic [1:0][9:0] load_ma;
   mode_t           mode;
   int              errors, samples_checked;
   localparam logic [6:0] ADDRS [5] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h7F};
   localparam logic [9:0] TH [4] = '{10'h258, 10'h320, 10'h0C8, 10'h190};
   lq_link_if link_if ();
   lq_device #(.WD_CYCLES(17'h000C8)) lq_device_inst (.clock, .sys_rst, .link(link_if),
      .fallback_request_in, .fallback_drive_in, .inrush_done, .load_ma, .fast_trip,
      .oc_confirm, .thermal_off, .vbb_uv, .ch_on, .fault_alert_out_n, .mode);
   lq_host lq_host_inst (.clock, .sys_rst, .link(link_if), .cmd_valid, .cmd_write, .cmd_addr,
      .cmd_wdata, .cmd_ready, .lq_enter_valid, .lq_sw_set, .lq_wake_cfg, .rsp_valid, .rsp_data);
   lq_link_monitor lq_link_monitor_inst (.clock, .sys_rst, .sclk(link_if.sclk),
      .cs_n(link_if.cs_n), .sdo_oe(link_if.sdo_oe), .mode, .ch_on, .fault_alert_out_n,
      .inrush_done, .fast_trip, .vbb_uv, .fallback_request_in, .fallback_drive_in);
   ////////////////////////////////////////////////////////////////////////
   task automatic tick();
      @(posedge clock);
      #2;
   endtask
   task automatic report_and_stop();
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready(input string what);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         tick();
         n++;
         if (n > 400) begin
            cmp(what, 16'h0001, 16'h0000);
            report_and_stop();
         end
      end
      tick();
   endtask
   task automatic wait_rsp();
      int n;
      n = 0;
      while (rsp_valid !== 1'b1) begin
         tick();
         n++;
         if (n > 400) begin
            cmp("rsp_valid", 16'h0001, 16'h0000);
            report_and_stop();
         end
      end
      r = rsp_data;
      tick();
   endtask
   task automatic frame(input logic w, input logic [6:0] a, input logic [15:0] d);
      {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
      wait_ready("cmd_ready");
      cmd_valid = 1'b0;
      wait_rsp();
   endtask
   task automatic rd(input logic [6:0] a);
      frame(1'b0, a, 16'h0000);
      frame(1'b0, 7'h00, 16'h0000);
   endtask
   task automatic wait_mode(input mode_t m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         tick();
         n++;
      end
      cmp("mode", 16'(m), 16'(mode));
      if (mode !== m) report_and_stop();
   endtask
   task automatic enter_lq(input logic [1:0] sw, input logic [15:0] cfg);
      {lq_sw_set, lq_wake_cfg, lq_enter_valid} = {sw, cfg, 1'b1};
      wait_ready("enter ready");
      lq_enter_valid = 1'b0;
      repeat (4) wait_rsp();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic check_reset_values();
      cmp("alert idle", 16'h0001, 16'(fault_alert_out_n));
      foreach (ADDRS[i]) begin
         rd(ADDRS[i]);
         cmp("register reset", 16'h0000, r);
      end
   endtask
   task automatic lowq_entry_and_exit();
      inrush_done = 2'b01;
      enter_lq(2'b11, 16'h0000);
      repeat (10) tick();
      cmp("waits inrush", 16'(ST_ENTRY), 16'(mode));
      cmp("outputs frozen", 16'h0003, 16'(ch_on));
      inrush_done = 2'b11;
      wait_mode(ST_LOWQ, 10);
      frame(1'b1, 7'h02, 16'h0000);
      frame(1'b1, 7'h01, 16'h0001);
      vbb_uv = 1'b1;
      repeat (2) tick();
      cmp("undervoltage off", 16'h0000, 16'(ch_on));
      vbb_uv = 1'b0;
      rd(7'h01);
      cmp("stays low-quiescent", 16'(ST_LOWQ), 16'(mode));
      cmp("outputs kept", 16'h0003, 16'(ch_on));
      frame(1'b1, 7'h01, 16'h0000);
      wait_mode(ST_ACTIVE, 10);
      rd(7'h02);
      cmp("switch retained", 16'h0003, r);
   endtask
   task automatic wake_thresholds();
      for (int c = 0; c < 4; c++) begin
         load_ma[0] = 10'h000;
         enter_lq(2'b01, {11'h000, 2'(c), 2'(c), 1'b0});
         wait_mode(ST_LOWQ, 10);
         load_ma[0] = TH[c];
         repeat (10) tick();
         cmp("no wake at threshold", 16'(ST_LOWQ), 16'(mode));
         load_ma[0] = TH[c] + 10'h001;
         wait_mode(ST_ACTIVE, 10);
         tick();
         cmp("alert falls", 16'h0000, 16'(fault_alert_out_n));
         rd(7'h01);
         cmp("low-power bit kept", 16'h0001, 16'(r[0]));
         rd(7'h04);
         cmp("wake flag", 16'h0002, r);
         cmp("alert released", 16'h0001, 16'(fault_alert_out_n));
      end
      load_ma[0] = 10'h000;
   endtask
   task automatic fallback_paths();
      frame(1'b1, 7'h02, 16'h0000);
      {fallback_drive_in, fallback_request_in} = 2'b11;
      wait_mode(ST_FALLBACK, 8);
      repeat (4) tick();
      cmp("drive high", 16'h0003, 16'(ch_on));
      cmp("fallback alert", 16'h0000, 16'(fault_alert_out_n));
      fallback_drive_in = 1'b0;
      repeat (4) tick();
      cmp("drive low", 16'h0000, 16'(ch_on));
      frame(1'b1, 7'h02, 16'h0003);
      frame(1'b1, 7'h04, 16'h0001);
      repeat (5) tick();
      cmp("pin still high", 16'(ST_FALLBACK), 16'(mode));
      fallback_request_in = 1'b0;
      repeat (4) tick();
      frame(1'b1, 7'h04, 16'h0001);
      wait_mode(ST_ACTIVE, 10);
      rd(7'h02);
      cmp("write rejected", 16'h0000, r);
      frame(1'b1, 7'h05, 16'h0001);
      wait_mode(ST_FALLBACK, 400);
      frame(1'b1, 7'h04, 16'h0001);
      wait_mode(ST_ACTIVE, 10);
      frame(1'b1, 7'h05, 16'h0000);
   endtask
   task automatic power_loss();
      frame(1'b1, 7'h02, 16'h0001);
      sys_rst = 1'b1;
      repeat (3) tick();
      sys_rst = 1'b0;
      tick();
      cmp("channels off", 16'h0000, 16'(ch_on));
      rd(7'h02);
      cmp("config lost", 16'h0000, r);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      {cmd_valid, cmd_write, cmd_addr, cmd_wdata, lq_enter_valid, lq_sw_set, lq_wake_cfg} = '0;
      {inrush_done, load_ma, fast_trip, oc_confirm, thermal_off} = '0;
      {vbb_uv, fallback_request_in, fallback_drive_in} = '0;
      errors = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      repeat (12) @(posedge clock);
      #2;
      sys_rst = 1'b0;
      check_reset_values();
      lowq_entry_and_exit();
      wake_thresholds();
      fallback_paths();
      power_loss();
      report_and_stop();
   end
endmodule
